// *** pmsb_bank.sv ***
`include "pmsb_params.svh"
module pmsb_bank
  import pmsb_pkg::*;
#(
  parameter int TICK_CYCLES = `PMSB_TICK_CYCLES
)
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic cmd_valid_in,
  input wire logic cmd_write_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic [15:0] cmd_wdata_in,
  output logic cmd_ack_out,
  output logic cmd_invalid_out,
  output logic [15:0] cmd_rdata_out,
  input wire logic start_in,
  input wire logic stop_in,
  input wire logic [15:0] vout_sense_in,
  input wire logic vout_uv_reached_in,
  input wire logic [7:0] vout_status_in,
  input wire logic [7:0] iout_status_in,
  input wire logic [7:0] input_status_in,
  input wire logic [3:0] temp_status_in,
  input wire logic [4:0] comm_status_in,
  input wire logic busy_in,
  input wire logic other_fault_in,
  input wire logic [15:0] vin_reading_in,
  input wire logic [15:0] vout_reading_in,
  input wire logic [15:0] iout_reading_in,
  output logic power_good_out,
  output logic ramp_enable_out,
  output logic energy_enable_out,
  output logic ton_max_fault_out
);
  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [15:0] pgood_negate_threshold_r;
  logic [15:0] turn_on_delay_r;
  logic [15:0] turn_on_rise_time_r;
  logic [15:0] turn_on_max_time_r;
  logic [7:0] turn_on_max_response_r;
  logic [15:0] turn_off_delay_r;
  logic [15:0] turn_off_fall_time_r;
  logic wr_ok;
  logic time_ok;
  logic is_time_cmd;

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  // Only exponent zero and in-range counts are accepted for timing words
  assign time_ok = (cmd_wdata_in[`PMSB_LIN11_EXP_MSB:`PMSB_LIN11_EXP_LSB] == 5'h00) &&
    (cmd_wdata_in[10:0] <= 11'(`PMSB_TIME_MAX_MS));
  assign is_time_cmd = (cmd_code_in == `PMSB_CMD_TON_DLY) ||
    (cmd_code_in == `PMSB_CMD_TURN_ON_RISE_TIME) || (cmd_code_in == `PMSB_CMD_TON_MAX) ||
    (cmd_code_in == `PMSB_CMD_TOFF_DLY) || (cmd_code_in == `PMSB_CMD_TURN_OFF_FALL_TIME);
  assign wr_ok = cmd_valid_in && cmd_write_in && (!is_time_cmd || time_ok);

  // Threshold holds a sixteen-bit linear mantissa at exponent minus eight
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      pgood_negate_threshold_r <= `PMSB_RST_PGOOD_OFF;
    else if (wr_ok && (cmd_code_in == `PMSB_CMD_PGOOD_OFF))
      pgood_negate_threshold_r <= cmd_wdata_in;
  end

  // Only bit 7 steers the sequencer; the whole byte reads back
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      turn_on_max_response_r <= `PMSB_RST_TON_MAX_RSP;
    else if (wr_ok && (cmd_code_in == `PMSB_CMD_TON_MAX_RSP))
      turn_on_max_response_r <= cmd_wdata_in[7:0];
  end

  // ----------------------------------------
  // Timing words
  // ----------------------------------------
  // Refused words never land, so every count stays within 0 to 127 ms
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      turn_on_delay_r <= `PMSB_RST_TON_DLY;
      turn_on_rise_time_r <= `PMSB_RST_TURN_ON_RISE_TIME;
      turn_on_max_time_r <= `PMSB_RST_TON_MAX;
      turn_off_delay_r <= `PMSB_RST_TOFF_DLY;
      turn_off_fall_time_r <= `PMSB_RST_TURN_OFF_FALL_TIME;
    end
    else if (wr_ok)
    begin
      case (cmd_code_in)
        `PMSB_CMD_TON_DLY: turn_on_delay_r <= cmd_wdata_in;
        `PMSB_CMD_TURN_ON_RISE_TIME: turn_on_rise_time_r <= cmd_wdata_in;
        `PMSB_CMD_TON_MAX: turn_on_max_time_r <= cmd_wdata_in;
        `PMSB_CMD_TOFF_DLY: turn_off_delay_r <= cmd_wdata_in;
        // Stored for readback only; the fall profile is not driven
        `PMSB_CMD_TURN_OFF_FALL_TIME: turn_off_fall_time_r <= cmd_wdata_in;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Millisecond base
  // ----------------------------------------
  pmsb_tick_if tick_if ();
  pmsb_state_t state_r;
  pmsb_state_t state_nxt;
  logic [6:0] ms_r;
  logic [6:0] max_ms_r;
  logic step;
  assign step = (state_nxt != state_r);

  pmsb_ms_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .run_in(!step),
    .tick_if(tick_if)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  logic max_expired;
  assign max_expired = (turn_on_max_time_r[6:0] != 7'h00) && tick_if.tick &&
    (max_ms_r + 7'h01 >= turn_on_max_time_r[6:0]) && !vout_uv_reached_in;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      PMSB_OFF:
        if (start_in)
          state_nxt = PMSB_ON_DELAY;
      PMSB_ON_DELAY:
        if (stop_in)
          state_nxt = PMSB_OFF;
        else if (ms_r >= turn_on_delay_r[6:0])
          state_nxt = PMSB_RISE;
      PMSB_RISE:
        if (stop_in)
          state_nxt = PMSB_OFF_DELAY;
        else if (max_expired && turn_on_max_response_r[`PMSB_RSP_SHUTDOWN_BIT])
          state_nxt = PMSB_FAULT_OFF;
        else if (ms_r >= turn_on_rise_time_r[6:0])
          state_nxt = PMSB_REGULATE;
      PMSB_REGULATE:
        if (stop_in)
          state_nxt = PMSB_OFF_DELAY;
        else if (max_expired && turn_on_max_response_r[`PMSB_RSP_SHUTDOWN_BIT])
          state_nxt = PMSB_FAULT_OFF;
      PMSB_OFF_DELAY:
        if (ms_r >= turn_off_delay_r[6:0])
          state_nxt = PMSB_OFF;
      PMSB_FAULT_OFF:
        if (stop_in)
          state_nxt = PMSB_OFF;
      default: state_nxt = PMSB_OFF;
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      state_r <= PMSB_OFF;
    else
      state_r <= state_nxt;
  end

  // Per-state millisecond counter, saturating
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      ms_r <= 7'h00;
    else if (step)
      ms_r <= 7'h00;
    else if (tick_if.tick && ms_r != 7'h7F)
      ms_r <= ms_r + 7'h01;
  end

  // Max-time counter spans the whole power-up, delay excluded
  logic powering;
  assign powering = (state_r == PMSB_RISE) || (state_r == PMSB_REGULATE);
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      max_ms_r <= 7'h00;
    else if (!powering || vout_uv_reached_in)
      max_ms_r <= 7'h00;
    else if (tick_if.tick && max_ms_r != 7'h7F)
      max_ms_r <= max_ms_r + 7'h01;
  end

  // Sticky until the next start; flagged even when the response is ignore
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      ton_max_fault_out <= 1'b0;
    else if (max_expired && powering)
      ton_max_fault_out <= 1'b1;
    else if (state_r == PMSB_OFF && start_in)
      ton_max_fault_out <= 1'b0;
  end

  // ----------------------------------------
  // Sequencer outputs
  // ----------------------------------------
  // Taken from the next state so the ramp starts on the edge of entry
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      ramp_enable_out <= 1'b0;
    else
      ramp_enable_out <= (state_nxt == PMSB_RISE) || (state_nxt == PMSB_REGULATE);
  end

  // Energy outlasts the ramp by the turn-off delay on a stop; a max-time shutdown drops both together
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      energy_enable_out <= 1'b0;
    else
      energy_enable_out <= (state_nxt == PMSB_RISE) || (state_nxt == PMSB_REGULATE) ||
        (state_nxt == PMSB_OFF_DELAY);
  end

  // ----------------------------------------
  // Power good
  // ----------------------------------------
  // Asserts the edge after regulation entry; the on-threshold compare lives elsewhere
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      power_good_out <= 1'b0;
    else if (state_r != PMSB_REGULATE || vout_sense_in <= pgood_negate_threshold_r)
      power_good_out <= 1'b0;
    else if (state_r == PMSB_REGULATE)
      power_good_out <= 1'b1;
  end

  // ----------------------------------------
  // Status composition
  // ----------------------------------------
  logic [7:0] summary_status_byte;
  logic [7:0] status_high;
  logic [7:0] temperature_status;
  logic [7:0] comm_logic_status;
  logic output_off;
  logic comm_any;
  logic temp_any;
  assign output_off = !energy_enable_out;
  assign temp_any = |temp_status_in;
  assign comm_any = |comm_status_in;
  assign temperature_status = {temp_status_in, 4'h0};
  assign comm_logic_status = {comm_status_in[4:1], 2'b00,
    comm_status_in[0], 1'b0};
  assign summary_status_byte = {busy_in, output_off, vout_status_in[7], iout_status_in[7],
    input_status_in[4], temp_any, comm_any, other_fault_in};
  assign status_high = {|vout_status_in, |iout_status_in, |input_status_in, 1'b0,
    !power_good_out, 3'b000};

  // ----------------------------------------
  // Host answer
  // ----------------------------------------
  logic [15:0] rdata_nxt;
  logic known;
  always_comb
  begin
    known = 1'b1;
    rdata_nxt = 16'h0000;
    case (cmd_code_in)
      `PMSB_CMD_PGOOD_OFF: rdata_nxt = pgood_negate_threshold_r;
      `PMSB_CMD_TON_DLY: rdata_nxt = turn_on_delay_r;
      `PMSB_CMD_TURN_ON_RISE_TIME: rdata_nxt = turn_on_rise_time_r;
      `PMSB_CMD_TON_MAX: rdata_nxt = turn_on_max_time_r;
      `PMSB_CMD_TON_MAX_RSP: rdata_nxt = {8'h00, turn_on_max_response_r};
      `PMSB_CMD_TOFF_DLY: rdata_nxt = turn_off_delay_r;
      `PMSB_CMD_TURN_OFF_FALL_TIME: rdata_nxt = turn_off_fall_time_r;
      `PMSB_CMD_STAT_BYTE: rdata_nxt = {8'h00, summary_status_byte};
      `PMSB_CMD_STAT_WORD: rdata_nxt = {status_high, summary_status_byte};
      `PMSB_CMD_STAT_VOUT: rdata_nxt = {8'h00, vout_status_in};
      `PMSB_CMD_STAT_IOUT: rdata_nxt = {8'h00, iout_status_in};
      `PMSB_CMD_STAT_INPUT: rdata_nxt = {8'h00, input_status_in};
      `PMSB_CMD_STAT_TEMP: rdata_nxt = {8'h00, temperature_status};
      `PMSB_CMD_STAT_COMM: rdata_nxt = {8'h00, comm_logic_status};
      `PMSB_CMD_RD_VIN: rdata_nxt = vin_reading_in;
      `PMSB_CMD_RD_VOUT: rdata_nxt = vout_reading_in;
      `PMSB_CMD_RD_IOUT: rdata_nxt = iout_reading_in;
      default: known = 1'b0;
    endcase
  end

  logic read_only;
  assign read_only = (cmd_code_in >= `PMSB_CMD_STAT_BYTE);

  // Every code is answered one edge later, refused or not
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      cmd_ack_out <= 1'b0;
    else
      cmd_ack_out <= cmd_valid_in;
  end

  // Bad exponent or count, write to read-only code or unknown code
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      cmd_invalid_out <= 1'b0;
    else
      cmd_invalid_out <= cmd_valid_in && (!known ||
        (cmd_write_in && (read_only || (is_time_cmd && !time_ok))));
  end

  // Zero outside read answers so a stale word never looks valid
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      cmd_rdata_out <= 16'h0000;
    else
      cmd_rdata_out <= (cmd_valid_in && !cmd_write_in) ? rdata_nxt : 16'h0000;
  end
endmodule

// *** pmsb_params.svh ***
`ifndef PMSB_PARAMS_SVH
`define PMSB_PARAMS_SVH
// ----------------------------------------
// Command codes
// ----------------------------------------
`define PMSB_CMD_PGOOD_OFF 8'h5F
`define PMSB_CMD_TON_DLY 8'h60
`define PMSB_CMD_TURN_ON_RISE_TIME 8'h61
`define PMSB_CMD_TON_MAX 8'h62
`define PMSB_CMD_TON_MAX_RSP 8'h63
`define PMSB_CMD_TOFF_DLY 8'h64
`define PMSB_CMD_TURN_OFF_FALL_TIME 8'h65
`define PMSB_CMD_STAT_BYTE 8'h78
`define PMSB_CMD_STAT_WORD 8'h79
`define PMSB_CMD_STAT_VOUT 8'h7A
`define PMSB_CMD_STAT_IOUT 8'h7B
`define PMSB_CMD_STAT_INPUT 8'h7C
`define PMSB_CMD_STAT_TEMP 8'h7D
`define PMSB_CMD_STAT_COMM 8'h7E
`define PMSB_CMD_RD_VIN 8'h88
`define PMSB_CMD_RD_VOUT 8'h8B
`define PMSB_CMD_RD_IOUT 8'h8C
// ----------------------------------------
// Reset values
// ----------------------------------------
`define PMSB_RST_PGOOD_OFF 16'h006C
`define PMSB_RST_TON_DLY 16'h0000
`define PMSB_RST_TURN_ON_RISE_TIME 16'h0002
`define PMSB_RST_TON_MAX 16'h0000
`define PMSB_RST_TON_MAX_RSP 8'h00
`define PMSB_RST_TOFF_DLY 16'h0000
`define PMSB_RST_TURN_OFF_FALL_TIME 16'h0001
// ----------------------------------------
// Fields and timing
// ----------------------------------------
`define PMSB_LIN11_EXP_MSB 15
`define PMSB_LIN11_EXP_LSB 11
`define PMSB_TIME_MAX_MS 127
`define PMSB_RSP_SHUTDOWN_BIT 7
`define PMSB_CLK_HZ 200000000
`define PMSB_TICK_MS 1
`define PMSB_TICK_CYCLES ((`PMSB_CLK_HZ / 1000) * `PMSB_TICK_MS)
`endif

// *** pmsb_pkg.sv ***
package pmsb_pkg;
  typedef enum logic [2:0] {
    PMSB_OFF = 3'b000,
    PMSB_ON_DELAY = 3'b001,
    PMSB_RISE = 3'b010,
    PMSB_REGULATE = 3'b011,
    PMSB_OFF_DELAY = 3'b100,
    PMSB_FAULT_OFF = 3'b101
  } pmsb_state_t;
endpackage

// *** pmsb_tick_if.sv ***
interface pmsb_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface

// *** pmsb_ms_tick.sv ***
`include "pmsb_params.svh"
module pmsb_ms_tick
  import pmsb_pkg::*;
#(
  parameter int TICK_CYCLES = `PMSB_TICK_CYCLES
)
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic run_in,
  pmsb_tick_if.src tick_if
);
  logic [31:0] count_r;
  logic tick_r;
  assign tick_if.tick = tick_r;
  // Restarts on each sequencing step so a delay counts whole milliseconds
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      count_r <= 32'h00000000;
      tick_r <= 1'b0;
    end
    else if (!run_in)
    begin
      count_r <= 32'h00000000;
      tick_r <= 1'b0;
    end
    else if (count_r == 32'(TICK_CYCLES - 1))
    begin
      count_r <= 32'h00000000;
      tick_r <= 1'b1;
    end
    else
    begin
      count_r <= count_r + 32'h00000001;
      tick_r <= 1'b0;
    end
  end
endmodule

// *** pmsb_bank_chk.sv ***
module pmsb_bank_chk
  import pmsb_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic cmd_valid_in,
  input wire logic cmd_write_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic cmd_ack_out,
  input wire logic cmd_invalid_out,
  input wire logic [15:0] cmd_rdata_out,
  input wire logic power_good_out,
  input wire logic ramp_enable_out,
  input wire logic energy_enable_out
);
  // ----
  // Command port
  // ----
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);
  wire logic rd_q = cmd_valid_in && !cmd_write_in;
  ack_follows_a: assert property (cmd_valid_in |=> cmd_ack_out)
    else $error("ack missing after command");
  ack_cause_a: assert property (cmd_ack_out |-> $past(cmd_valid_in))
    else $error("ack without command");
  invalid_with_ack_a: assert property (cmd_invalid_out |-> cmd_ack_out)
    else $error("refusal without ack");
  ro_refuse_a: assert property (cmd_valid_in && cmd_write_in && cmd_code_in >= 8'h78
    |=> cmd_invalid_out) else $error("read-only write taken");
  byte_high_zero_a: assert property (rd_q && cmd_code_in == 8'h78
    |=> cmd_rdata_out[15:8] == 8'h00) else $error("summary byte high bits set");
  word_reserved_a: assert property (rd_q && cmd_code_in == 8'h79
    |=> !cmd_rdata_out[12] && cmd_rdata_out[10:8] == 3'h0) else $error("word reserved set");
  temp_reserved_a: assert property (rd_q && cmd_code_in == 8'h7D
    |=> cmd_rdata_out[3:0] == 4'h0) else $error("temp reserved set");
  comm_fixed_a: assert property (rd_q && cmd_code_in == 8'h7E
    |=> cmd_rdata_out[3:2] == 2'h0 && !cmd_rdata_out[0]) else $error("comm fixed bits set");
  // ----
  // Sequencer
  // ----
  ramp_energy_a: assert property (ramp_enable_out |-> energy_enable_out)
    else $error("ramp without energy");
  pgood_reg_a: assert property ($rose(power_good_out) |-> ramp_enable_out)
    else $error("power good outside regulation");
  cover property (cmd_invalid_out);
  cover property ($rose(power_good_out));
  cover property ($fell(energy_enable_out));
endmodule

bind pmsb_bank pmsb_bank_chk i_pmsb_bank_chk (.clk_in, .reset_n_in, .cmd_valid_in,
  .cmd_write_in, .cmd_code_in, .cmd_ack_out, .cmd_invalid_out, .cmd_rdata_out,
  .power_good_out, .ramp_enable_out, .energy_enable_out);

// *** pmsb_host_model.sv ***
module pmsb_host_model
(
  input wire logic clk_in,
  output logic valid_out,
  output logic write_out,
  output logic [7:0] code_out,
  output logic [15:0] wdata_out,
  input wire logic ack_in,
  input wire logic invalid_in,
  input wire logic [15:0] rdata_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    valid_out = 1'b0;
    write_out = 1'b0;
    code_out = 8'h00;
    wdata_out = 16'h0000;
  end
  // ----
  // One command, answer taken one edge after the taking edge
  // ----
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
    output logic [15:0] rd, output logic inv);
    @(posedge clk_in);
    valid_out <= 1'b1;
    write_out <= w;
    code_out <= c;
    wdata_out <= d;
    @(posedge clk_in);
    valid_out <= 1'b0;
    // Released lines flip so stale values never look valid
    code_out <= ~c;
    wdata_out <= ~d;
    @(posedge clk_in);
    rd = ack_in ? rdata_in : 16'hXXXX;
    inv = ack_in ? invalid_in : 1'bx;
  endtask
endmodule

// *** tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pmsb_pkg::*;
  typedef struct {logic w; logic [7:0] c; logic [15:0] d; logic [15:0] er; logic ei;} pmsb_row_t;
  logic clk_in, reset_n_in, cmd_valid_in, cmd_write_in, cmd_ack_out, cmd_invalid_out;
  logic [7:0] cmd_code_in, vout_status_in, iout_status_in, input_status_in;
  logic [15:0] cmd_wdata_in, cmd_rdata_out, vout_sense_in, rd;
  logic [15:0] vin_reading_in, vout_reading_in, iout_reading_in;
  logic [3:0] temp_status_in;
  logic [4:0] comm_status_in;
  logic start_in, stop_in, vout_uv_reached_in, busy_in, other_fault_in, inv;
  logic power_good_out, ramp_enable_out, energy_enable_out, ton_max_fault_out;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  int n;
  // ----
  // Ordinary cases
  // ----
  pmsb_row_t rows [] = '{
    '{0, 8'h5F, 16'h0000, 16'h006C, 0},
    '{0, 8'h60, 16'h0000, 16'h0000, 0},
    '{0, 8'h61, 16'h0000, 16'h0002, 0},
    '{0, 8'h62, 16'h0000, 16'h0000, 0},
    '{0, 8'h63, 16'h0000, 16'h0000, 0},
    '{0, 8'h64, 16'h0000, 16'h0000, 0},
    '{0, 8'h65, 16'h0000, 16'h0001, 0},
    '{1, 8'h60, 16'h0003, 16'h0000, 0},
    '{1, 8'h60, 16'h0803, 16'h0000, 1},
    '{1, 8'h60, 16'h0080, 16'h0000, 1},
    '{0, 8'h60, 16'h0000, 16'h0003, 0},
    '{1, 8'h64, 16'h0002, 16'h0000, 0},
    '{1, 8'h65, 16'h0005, 16'h0000, 0},
    '{1, 8'h78, 16'h0000, 16'h0000, 1},
    '{0, 8'h70, 16'h0000, 16'hXXXX, 1},
    '{0, 8'h78, 16'h0000, 16'h006E, 0},
    '{0, 8'h79, 16'h0000, 16'hE86E, 0},
    '{0, 8'h7A, 16'h0000, 16'h0080, 0},
    '{0, 8'h7B, 16'h0000, 16'h0001, 0},
    '{0, 8'h7C, 16'h0000, 16'h0010, 0},
    '{0, 8'h7D, 16'h0000, 16'h00A0, 0},
    '{0, 8'h7E, 16'h0000, 16'h00A2, 0},
    '{0, 8'h88, 16'h0000, 16'h1234, 0},
    '{0, 8'h8B, 16'h0000, 16'h0180, 0},
    '{0, 8'h8C, 16'h0000, 16'h0ABC, 0}};

  pmsb_bank #(.TICK_CYCLES(20)) i_pmsb_bank (.clk_in, .reset_n_in, .cmd_valid_in,
    .cmd_write_in, .cmd_code_in, .cmd_wdata_in, .cmd_ack_out, .cmd_invalid_out,
    .cmd_rdata_out, .start_in, .stop_in, .vout_sense_in, .vout_uv_reached_in,
    .vout_status_in, .iout_status_in, .input_status_in, .temp_status_in,
    .comm_status_in, .busy_in, .other_fault_in, .vin_reading_in, .vout_reading_in,
    .iout_reading_in, .power_good_out, .ramp_enable_out, .energy_enable_out,
    .ton_max_fault_out);
  pmsb_host_model i_pmsb_host_model (.clk_in, .valid_out(cmd_valid_in),
    .write_out(cmd_write_in), .code_out(cmd_code_in), .wdata_out(cmd_wdata_in),
    .ack_in(cmd_ack_out), .invalid_in(cmd_invalid_out), .rdata_in(cmd_rdata_out));

  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // Ceiling far above the few hundred cycles the run needs
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_for(input int sel, output int cnt);
    logic hit;
    cnt = 0;
    hit = 1'b0;
    while (!hit && cnt < 1000)
    begin
      @(posedge clk_in);
      cnt++;
      case (sel)
        0: hit = ramp_enable_out === 1'b1;
        1: hit = power_good_out === 1'b1;
        2: hit = power_good_out === 1'b0;
        3: hit = energy_enable_out === 1'b0;
        default: hit = ton_max_fault_out === 1'b1;
      endcase
    end
  endtask

  task automatic pulse(input logic stop);
    @(posedge clk_in);
    start_in <= !stop;
    stop_in <= stop;
    @(posedge clk_in);
    start_in <= 1'b0;
    stop_in <= 1'b0;
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    reset_n_in = 1'b0;
    {start_in, stop_in, vout_uv_reached_in, busy_in, other_fault_in} = 5'h00;
    vout_sense_in = 16'h0100;
    {vout_status_in, iout_status_in, input_status_in} = {8'h80, 8'h01, 8'h10};
    temp_status_in = 4'hA;
    comm_status_in = 5'h15;
    {vin_reading_in, vout_reading_in, iout_reading_in} = {16'h1234, 16'h0180, 16'h0ABC};
    repeat (10) @(posedge clk_in);
    reset_n_in <= 1'b1;
    foreach (rows[i])
    begin
      i_pmsb_host_model.xfer(rows[i].w, rows[i].c, rows[i].d, rd, inv);
      chk({15'h0000, inv}, {15'h0000, rows[i].ei});
      if (rows[i].er !== 16'hXXXX)
        chk(rd, rows[i].er);
    end
    // ----
    // Turn-on, power good, turn-off
    // ----
    pulse(1'b0);
    wait_for(0, n);
    chk(16'(n >= 55 && n <= 66), 16'h0001);
    wait_for(1, n);
    chk(16'(n >= 36 && n <= 46), 16'h0001);
    chk({15'h0000, ton_max_fault_out}, 16'h0000);
    vout_sense_in <= 16'h006C;
    wait_for(2, n);
    chk(16'(n <= 3), 16'h0001);
    pulse(1'b1);
    wait_for(3, n);
    chk(16'(n >= 36 && n <= 46), 16'h0001);
    // ----
    // Max-time fault with shutdown response
    // ----
    i_pmsb_host_model.xfer(1'b1, 8'h62, 16'h0001, rd, inv);
    i_pmsb_host_model.xfer(1'b1, 8'h63, 16'h0080, rd, inv);
    pulse(1'b0);
    wait_for(4, n);
    chk(16'(n >= 15 && n <= 90), 16'h0001);
    repeat (3) @(posedge clk_in);
    chk({15'h0000, energy_enable_out}, 16'h0000);
    pulse(1'b1);
    // ----
    // Reset in mid-run restores defaults
    // ----
    reset_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'b1;
    i_pmsb_host_model.xfer(1'b0, 8'h60, 16'h0000, rd, inv);
    chk(rd, 16'h0000);
    chk({15'h0000, power_good_out}, 16'h0000);
    // ----
    // Max-time fault with the default ignore response
    // ----
    i_pmsb_host_model.xfer(1'b1, 8'h62, 16'h0001, rd, inv);
    pulse(1'b0);
    wait_for(4, n);
    chk(16'(n >= 18 && n <= 26), 16'h0001);
    chk({14'h0000, ramp_enable_out, energy_enable_out}, 16'h0003);
    pulse(1'b1);
    wait_for(3, n);
    chk(16'(n <= 3), 16'h0001);
    conclude();
  end
endmodule
